// file: logic/fdc_pkg.sv
// Behaviour
// - four BCD decades count together, up or down, on each rising count edge.
// - reset pin high clears decades, parks scan on top digit, blanks strobes.
// - direction low counts up, direction high counts down.
// - carry outputs of decades two to four rest low, echo causing count pulse.
// - transfer high loads storage register from decades continuously.
// - shift clock idles high; storage shifts on rising end of each low pulse.
// - idle serial output shows lowest bit of bottom stored digit.
// - four digit strobes activate one at a time in sequence.
// - strobe active level follows polarity input: high gives high, low gives low.
// - BCD outputs, weighted 8-4-2-1, carry the selected stored digit.
// - external digit clock replaces internal oscillator when control bit 0 is set; reset clears it, keeping oscillator.
// - carry fires on decade overflow counting up or underflow counting down.
// - scan runs from thousands digit down to units digit, then repeats.
// - segment and BCD outputs settle before the digit strobe activates.
// - segment drives follow a fixed digit-to-segment table for zero to nine.
package fdc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_NS        = 50;
  localparam int OSC_HZ        = 2000;
  localparam int OSC_CYCLES    = CLK_HZ / OSC_HZ;
  localparam int SETTLE_NS     = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_COUNT  = 8'h04;
  localparam logic [7:0]  ADDR_STORE  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS = 8'h0c;
  localparam int          CTRL_EXT    = 0;
  localparam logic        CTRL_RST    = 1'b0;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [1:0]  TOP_DIGIT   = 2'h3;
  localparam logic [3:0]  DEC_MAX     = 4'h9;
  typedef enum logic [1:0] {SCAN_SETTLE = 2'b01, SCAN_SHOW = 2'b10} scan_e;
  // bit 0 = segment a ... bit 6 = segment g, 1 = transistor on
  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0:    seg7 = 7'h3f;
      4'h1:    seg7 = 7'h06;
      4'h2:    seg7 = 7'h5b;
      4'h3:    seg7 = 7'h4f;
      4'h4:    seg7 = 7'h66;
      4'h5:    seg7 = 7'h6d;
      4'h6:    seg7 = 7'h7d;
      4'h7:    seg7 = 7'h07;
      4'h8:    seg7 = 7'h7f;
      4'h9:    seg7 = 7'h6f;
      default: seg7 = 7'h00;
    endcase
  endfunction
endpackage

// file: logic/fdc_top.sv
`timescale 1ns/1ns
module fdc_top import fdc_pkg::*; #(
  parameter int OSC_DIV = OSC_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // counter pins
  input  wire logic        count_in,
  input  wire logic        dir_down,
  input  wire logic        reset_in,
  output logic      [2:0]  carry_out,
  // storage pins
  input  wire logic        transfer,
  input  wire logic        shift_clk_n,
  output logic             serial_out,
  // display pins
  input  wire logic        polarity,
  input  wire logic        digit_clk,
  output logic      [3:0]  digit_strobe,
  output logic      [3:0]  bcd_out,
  output logic      [6:0]  seg_out,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [6:0] s1;
  logic [6:0] s2;
  logic [2:0] s3;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      // idle levels: shift clock high, polarity high, so no false edge follows reset
      s1 <= 7'h21;
      s2 <= 7'h21;
      s3 <= 3'h2;
    end else begin
      s1 <= {count_in, shift_clk_n, digit_clk, dir_down, transfer, reset_in, polarity};
      s2 <= s1;
      s3 <= s2[6:4];
    end
  end
  logic cnt_lvl, cnt_rise, shift_rise, dclk_rise, dir_s, xfer_s, rst_s, pol_s;
  assign cnt_lvl    = s2[6];
  assign cnt_rise   = s2[6] & ~s3[2];
  assign shift_rise = s2[5] & ~s3[1];
  assign dclk_rise  = s2[4] & ~s3[0];
  assign dir_s      = s2[3];
  assign xfer_s     = s2[2];
  assign rst_s      = s2[1];
  assign pol_s      = s2[0];

  // ----------------------------------------------------------------
  // decades, carries, storage
  // ----------------------------------------------------------------
  logic [15:0] count, next_count;
  logic [15:0] store, next_store;
  logic [2:0]  next_carry;
  logic        ext_sel;
  logic        en;
  logic        at_end;
  logic [3:0]  d;
  logic [3:0]  fire;
  always_comb begin
    next_count = count;
    next_store = store;
    next_carry = carry_out;
    en         = 1'b1;
    fire       = 4'h0;
    at_end     = 1'b0;
    d          = 4'h0;
    if (cnt_rise) begin
      for (int i = 0; i < 4; i++) begin
        d      = count[4*i +: 4];
        at_end = dir_s ? (d == 4'h0) : (d == DEC_MAX);
        if (en) begin
          if (dir_s)
            next_count[4*i +: 4] = at_end ? DEC_MAX : d - 4'h1;
          else
            next_count[4*i +: 4] = at_end ? 4'h0 : d + 4'h1;
        end
        fire[i] = en & at_end;
        en      = en & at_end;
      end
      next_carry = fire[3:1];
    end else if (!cnt_lvl) begin
      next_carry = 3'h0;
    end
    if (xfer_s)
      next_store = count;
    else if (shift_rise)
      next_store = {store[0], store[15:1]};
    if (rst_s) begin
      next_count = 16'h0000;
      next_carry = 3'h0;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count     <= 16'h0000;
      store     <= 16'h0000;
      carry_out <= 3'h0;
    end else begin
      count     <= next_count;
      store     <= next_store;
      carry_out <= next_carry;
    end
  end
  // lsb of the bottom digit leaves first; recirculation keeps it readable
  assign serial_out = store[0];

  // ----------------------------------------------------------------
  // digit scan and display
  // ----------------------------------------------------------------
  logic [$clog2(OSC_DIV)-1:0]       osc, next_osc;
  logic [$clog2(SETTLE_CYCLES):0]   settle, next_settle;
  logic [1:0]  sel, next_sel;
  scan_e       scan, next_scan;
  logic        step;
  logic [3:0]  next_strobe, next_bcd, onehot;
  logic [6:0]  next_seg;
  always_comb begin
    next_osc    = (osc == OSC_DIV[$bits(osc)-1:0] - 1'b1) ? '0 : osc + 1'b1;
    step        = ext_sel ? dclk_rise : (osc == '0);
    next_sel    = sel;
    next_scan   = scan;
    next_settle = settle;
    case (scan)
      SCAN_SETTLE: begin
        next_settle = settle + 1'b1;
        if (settle == SETTLE_CYCLES[$bits(settle)-1:0] - 1'b1)
          next_scan = SCAN_SHOW;
      end
      SCAN_SHOW: begin
        if (step) begin
          next_sel    = sel - 2'h1;
          next_scan   = SCAN_SETTLE;
          next_settle = '0;
        end
      end
      default: next_scan = SCAN_SETTLE;
    endcase
    if (rst_s) begin
      next_sel    = TOP_DIGIT;
      next_scan   = SCAN_SETTLE;
      next_settle = '0;
    end
    onehot      = 4'h1 << next_sel;
    next_strobe = (next_scan == SCAN_SHOW) ? (pol_s ? onehot : ~onehot)
                                           : {4{~pol_s}};
    next_bcd    = store[4*sel +: 4];
    next_seg    = seg7(next_bcd);
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      osc          <= '0;
      settle       <= '0;
      sel          <= TOP_DIGIT;
      scan         <= SCAN_SETTLE;
      digit_strobe <= 4'h0;
      bcd_out      <= 4'h0;
      // segments of digit zero, so they agree with the cleared bcd_out
      seg_out      <= 7'h3f;
    end else begin
      osc          <= next_osc;
      settle       <= next_settle;
      sel          <= next_sel;
      scan         <= next_scan;
      digit_strobe <= next_strobe;
      bcd_out      <= next_bcd;
      seg_out      <= next_seg;
    end
  end

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic        w_lane0, next_w_lane0;
  logic        next_ext_sel, next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        aw_go, w_go;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  always_comb begin
    aw_go        = s_axi_awvalid & s_axi_awready;
    w_go         = s_axi_wvalid & s_axi_wready;
    next_aw_held = aw_held | aw_go;
    next_w_held  = w_held | w_go;
    next_aw_addr = aw_go ? s_axi_awaddr : aw_addr;
    next_w_data  = w_go ? s_axi_wdata : w_data;
    next_w_lane0 = w_go ? s_axi_wstrb[0] : w_lane0;
    next_ext_sel = ext_sel;
    next_bvalid  = s_axi_bvalid & ~s_axi_bready;
    next_bresp   = s_axi_bresp;
    if (next_aw_held && next_w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_SLVERR;
      if (next_aw_addr == ADDR_CTRL) begin
        next_bresp = RESP_OKAY;
        if (next_w_lane0)
          next_ext_sel = next_w_data[CTRL_EXT];
      end
    end
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (s_axi_araddr == ADDR_CTRL)
        next_rdata = {31'h0, ext_sel};
      else if (s_axi_araddr == ADDR_COUNT)
        next_rdata = {16'h0, count};
      else if (s_axi_araddr == ADDR_STORE)
        next_rdata = {16'h0, store};
      else if (s_axi_araddr == ADDR_STATUS)
        next_rdata = {27'h0, scan == SCAN_SHOW, dir_s, rst_s, sel};
      else begin
        next_rdata = 32'h0;
        next_rresp = RESP_SLVERR;
      end
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0;
      w_lane0      <= 1'b0;
      ext_sel      <= CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_data       <= next_w_data;
      w_lane0      <= next_w_lane0;
      ext_sel      <= next_ext_sel;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_wrap_up;
    cnt_rise && !dir_s && !rst_s && count == 16'h9999 |=> count == 16'h0000;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("up wrap wrong");
  property p_count_down;
    cnt_rise && dir_s && !rst_s && count == 16'h0000 |=> count == 16'h9999 && carry_out == 3'h7;
  endproperty
  a_count_down: assert property (p_count_down) else $error("down wrap wrong");
  property p_reset_park;
    rst_s |=> count == 16'h0000 && sel == TOP_DIGIT && digit_strobe == {4{~$past(pol_s)}};
  endproperty
  a_reset_park: assert property (p_reset_park) else $error("reset state wrong");
  property p_carry_rest;
    !cnt_lvl ##1 !cnt_lvl |=> carry_out == 3'h0;
  endproperty
  a_carry_rest: assert property (p_carry_rest) else $error("carry not low");
  property p_transfer;
    xfer_s |=> store == $past(count);
  endproperty
  a_transfer: assert property (p_transfer) else $error("transfer missed");
  property p_shift;
    shift_rise && !xfer_s |=> store == {$past(store[0]), $past(store[15:1])};
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");
  property p_single_strobe;
    ##1 $countones(digit_strobe ^ {4{~$past(pol_s)}}) <= 1;
  endproperty
  a_single_strobe: assert property (p_single_strobe) else $error("two strobes");
  property p_scan_order;
    scan == SCAN_SHOW && step && !rst_s |=> sel == $past(sel) - 2'h1;
  endproperty
  a_scan_order: assert property (p_scan_order) else $error("scan order wrong");
  property p_ghost;
    $rose(scan == SCAN_SHOW) |-> $past(sel, 2) == sel &&
      $past(bcd_out) == $past(store[4*sel +: 4], 2);
  endproperty
  a_ghost: assert property (p_ghost) else $error("strobe before settle");
  property p_bcd;
    ##1 bcd_out == $past(store[4*sel +: 4]) && seg_out == seg7(bcd_out);
  endproperty
  a_bcd: assert property (p_bcd) else $error("bcd or segments wrong");
endmodule // fdc_top

// file: verification/fdc_partner.sv
`timescale 1ns/1ns
module fdc_partner (
  // clock
  input  wire logic        mclk,
  // count source
  output logic             count_in,
  output logic             dir_down,
  // display glass
  input  wire logic        polarity,
  input  wire logic [3:0]  digit_strobe,
  input  wire logic [3:0]  bcd_out,
  output logic      [15:0] shown
);
  logic [3:0] lit;

  initial begin
    count_in = 1'b0;
    dir_down = 1'b0;
    shown    = 16'h0000;
  end

  // ----------------------------------------------------------------
  // display: each digit glows until its strobe comes round again
  // ----------------------------------------------------------------
  assign lit = polarity ? digit_strobe : ~digit_strobe;

  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (lit == 4'(1 << i)) begin
        shown[4*i +: 4] <= bcd_out;
      end
    end
  end

  // ----------------------------------------------------------------
  // count source: three cycles high, three low, above the minimum width
  // ----------------------------------------------------------------
  task automatic pulses(input int n, input logic down);
    dir_down <= down;
    for (int k = 0; k < n; k++) begin
      @(posedge mclk);
      count_in <= 1'b1;
      repeat (3) @(posedge mclk);
      count_in <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    repeat (4) @(posedge mclk);
  endtask
endmodule  // fdc_partner

// file: verification/four_decade_counter_display_driver_tb_top.sv
`timescale 1ns/1ns
module four_decade_counter_display_driver_tb_top import fdc_pkg::*;;
  localparam logic [6:0] SEG_TAB [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d,
                                          7'h7d, 7'h07, 7'h7f, 7'h6f};
  logic        mclk = 1'b0, rstn = 1'b0, reset_in = 1'b0, transfer = 1'b0;
  logic        shift_clk_n = 1'b1, polarity = 1'b1, digit_clk = 1'b0;
  logic        count_in, dir_down, serial_out;
  logic [2:0]  carry_out, carry_q = 3'h0;
  logic [3:0]  digit_strobe, bcd_out, s_axi_wstrb = 4'hf;
  logic [6:0]  seg_out;
  logic [15:0] shown;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          err_count = 0, n_checks = 0, hits [3] = '{0, 0, 0};

  always #25 mclk = ~mclk;

  // a short oscillator divide keeps the scan tests brief
  fdc_top #(.OSC_DIV(32)) u_dut (.mclk, .rstn, .count_in, .dir_down, .reset_in, .carry_out,
    .transfer, .shift_clk_n, .serial_out, .polarity, .digit_clk, .digit_strobe, .bcd_out,
    .seg_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fdc_partner u_src (.mclk, .count_in, .dir_down, .polarity, .digit_strobe, .bcd_out, .shown);

  // carries are counted as separate rising pulses
  always @(posedge mclk) begin
    carry_q <= carry_out;
    for (int b = 0; b < 3; b++) if (carry_out[b] && !carry_q[b]) hits[b] <= hits[b] + 1;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && t < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
    @(posedge mclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      t++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && t < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
    @(posedge mclk);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reg_run();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(ADDR_CTRL, d, r);
    chk("ctrl_reset", 32'h0, d);
    axi_rd(8'h10, d, r);
    chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped_data", 32'h0, d);
    axi_wr(ADDR_COUNT, 32'h1234, r);
    chk("ro_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
  endtask

  task automatic count_run(input int n, input logic dn, input logic [2:0] ec, input logic [15:0] ev);
    int          b0 [3];
    logic [2:0]  got;
    logic [31:0] d;
    logic [1:0]  r;
    b0 = hits;
    u_src.pulses(n, dn);
    for (int b = 0; b < 3; b++) got[b] = (hits[b] != b0[b]);
    chk("carry", {29'h0, ec}, {29'h0, got});
    chk("carry_rest", 32'h0, {29'h0, carry_out});
    axi_rd(ADDR_COUNT, d, r);
    chk("count", {16'h0, ev}, d);
  endtask

  task automatic shift_run(input logic [15:0] v);
    logic [31:0] d;
    logic [1:0]  r;
    transfer <= 1'b1;
    repeat (6) @(posedge mclk);
    transfer <= 1'b0;
    repeat (6) @(posedge mclk);
    axi_rd(ADDR_STORE, d, r);
    chk("store", {16'h0, v}, d);
    for (int k = 0; k < 16; k++) begin
      chk("serial", {31'h0, v[k]}, {31'h0, serial_out});
      shift_clk_n <= 1'b0;
      repeat (3) @(posedge mclk);
      shift_clk_n <= 1'b1;
      repeat (5) @(posedge mclk);
    end
    axi_rd(ADDR_STORE, d, r);
    chk("store_recirc", {16'h0, v}, d);
  endtask

  task automatic reset_pin_run();
    logic [31:0] d;
    logic [1:0]  r;
    reset_in <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("blank", {28'h0, ~{4{polarity}}}, {28'h0, digit_strobe});
    axi_rd(ADDR_COUNT, d, r);
    chk("count_clear", 32'h0, d);
    axi_rd(ADDR_STATUS, d, r);
    chk("status", 32'hf, d);
    repeat (200) @(posedge mclk);
    reset_in <= 1'b0;
    // the first strobe after release must be the top digit, whatever the oscillator phase
    for (int k = 0; k < 60 && digit_strobe === ~{4{polarity}}; k++) @(posedge mclk);
    chk("park_top", 32'h8, {28'h0, digit_strobe});
  endtask

  task automatic scan_run(input int cycles, input logic [15:0] v);
    logic [3:0] act, pb;
    int         idx, prev, steps;
    prev = -1;
    steps = 0;
    pb = bcd_out;
    repeat (cycles) begin
      @(posedge mclk);
      act = polarity ? digit_strobe : ~digit_strobe;
      idx = -1;
      for (int i = 0; i < 4; i++) if (act === 4'(1 << i)) idx = i;
      if (act !== 4'h0) begin
        chk("one_hot", 32'h1, {31'h0, idx >= 0});
        chk("bcd", {28'h0, v[4*idx +: 4]}, {28'h0, bcd_out});
        chk("seg", {25'h0, SEG_TAB[v[4*idx +: 4]]}, {25'h0, seg_out});
        if (idx != prev) begin
          chk("settled", {28'h0, v[4*idx +: 4]}, {28'h0, pb});
          if (prev >= 0) chk("order", (prev + 3) % 4, idx);
          steps++;
          prev = idx;
        end
      end
      pb = bcd_out;
    end
    chk("steps", 32'h1, {31'h0, steps >= 5});
  endtask

  task automatic ext_run();
    logic [3:0]  a0;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(ADDR_CTRL, 32'h1, r);
    axi_rd(ADDR_CTRL, d, r);
    chk("ctrl_rw", 32'h1, d);
    repeat (30) @(posedge mclk);
    a0 = digit_strobe;
    repeat (200) @(posedge mclk);
    chk("ext_hold", {28'h0, a0}, {28'h0, digit_strobe});
    digit_clk <= 1'b1;
    repeat (3) @(posedge mclk);
    digit_clk <= 1'b0;
    repeat (40) @(posedge mclk);
    chk("ext_step", {28'h0, a0[0], a0[3:1]}, {28'h0, digit_strobe});
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    reg_run();
    count_run(99, 1'b0, 3'b000, 16'h0099);
    count_run(1, 1'b0, 3'b001, 16'h0100);
    count_run(1, 1'b1, 3'b001, 16'h0099);
    count_run(2, 1'b1, 3'b000, 16'h0097);
    shift_run(16'h0097);
    reset_pin_run();
    count_run(1, 1'b1, 3'b111, 16'h9999);
    count_run(1, 1'b0, 3'b111, 16'h0000);
    transfer <= 1'b1;
    count_run(1234, 1'b0, 3'b011, 16'h1234);
    scan_run(400, 16'h1234);
    chk("shown", 32'h1234, {16'h0, shown});
    polarity <= 1'b0;
    repeat (10) @(posedge mclk);
    scan_run(300, 16'h1234);
    ext_run();
    final_report();
  end

  // whole run is near 9500 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    final_report();
  end
endmodule  // four_decade_counter_display_driver_tb_top
